// File: core/pll_and_clock_switch_control.sv
// PLL and clock switch control registers behind an AXI4-Lite slave
`timescale 1ns/100ps
`include "clkctl_consts.svh"

module pll_and_clock_switch_control
  import clkctl_pkg::*;
#(
  parameter logic [3:0] ext_clk_code = 4'h0,
  parameter logic [3:0] ext_osc_code = 4'h1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic pll_lock_raw,
  input wire logic clk_avail_raw,
  input wire logic sys_src_is_pll,
  input wire logic rc_active_in,
  input wire logic [3:0] current_source_code,
  input wire logic [3:0] boot_source_fuse,
  input wire logic [1:0] startup_fuse,
  input wire logic clock_output_fuse,
  output logic pll_enable,
  output logic pll_locked,
  output logic [3:0] pll_mult_factor,
  output logic pll_factor_ok,
  output logic rc_enable,
  output logic rc_freq_select,
  output logic clock_ready_flag,
  output logic cmd_strobe,
  output logic [3:0] cmd_op,
  output logic [3:0] cmd_source,
  output logic [1:0] cmd_startup,
  output logic cmd_clkout
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Word decode; anything above the index field must be zero
  function automatic reg_t reg_sel(input logic [31:0] addr);
    reg_sel = REG_NONE;
    if (addr[31:10] == `ADDR_HI_ZERO)
    begin
      case (addr[9:2])
        `IDX_PLL: reg_sel = REG_PLL;
        `IDX_MCU: reg_sel = REG_MCU;
        `IDX_CMD: reg_sel = REG_CMD;
        `IDX_SEL: reg_sel = REG_SEL;
        default: reg_sel = REG_NONE;
      endcase
    end
  endfunction

  // Only the listed multiplication codes give a defined frequency
  function automatic logic factor_ok(input logic [3:0] f);
    factor_ok = (f >= `PLL_F_MIN) && (f <= `PLL_F_MAX);
  endfunction

  state_t s_reg;
  state_t s_next;
  logic avail_cmd;
  logic key_wr;
  logic cmd_wr;
  logic [7:0] rd;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Bus handshakes; a finished write blocks new ones until bready
  assign awready = !s_reg.aw_full && !s_reg.bvalid;
  assign wready = !s_reg.w_full && !s_reg.bvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = !s_reg.rvalid;
  assign rvalid = s_reg.rvalid;
  assign rdata = {24'h00_0000, s_reg.rdata};
  assign rresp = s_reg.rresp;

  // Clock control levels
  assign pll_enable = s_reg.pll_on | sys_src_is_pll;
  assign rc_enable = rc_active_in | pll_enable;
  assign pll_locked = s_reg.lock_s2 & pll_enable;
  assign pll_mult_factor = s_reg.pll_factor;
  assign pll_factor_ok = factor_ok(s_reg.pll_factor);
  assign rc_freq_select = s_reg.rc_sel;
  assign clock_ready_flag = s_reg.ready;
  assign cmd_strobe = s_reg.strobe;
  assign cmd_op = s_reg.op;
  assign cmd_source = s_reg.csel;
  assign cmd_startup = s_reg.csut;
  assign cmd_clkout = s_reg.clock_output_setting;

  // Write events seen by the checks below
  assign key_wr = s_reg.aw_full && s_reg.w_full && s_reg.w_lane
    && (s_reg.aw_reg == REG_CMD) && (s_reg.w_data == `UNLOCK_KEY);
  assign cmd_wr = s_reg.aw_full && s_reg.w_full && s_reg.w_lane
    && (s_reg.aw_reg == REG_CMD) && !s_reg.w_data[`CMD_UNLOCK_BIT];

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  always_comb
  begin
    rd = 8'h00;
    unique case (reg_sel(araddr))
      REG_PLL:
      begin
        rd[`PLL_F_MSB:`PLL_F_LSB] = s_reg.pll_factor;
        rd[`PLL_ON_BIT] = pll_enable;
        rd[`PLL_LOCK_BIT] = pll_locked;
      end
      REG_MCU: rd[`RC_SEL_BIT] = s_reg.rc_sel;
      REG_CMD:
      begin
        // Bits 6:5 stay zero
        rd[`CMD_UNLOCK_BIT] = s_reg.unlock;
        rd[`CMD_READY_BIT] = s_reg.ready;
        rd[`CMD_CODE_MSB:0] = s_reg.cmd_code;
      end
      REG_SEL:
      begin
        rd[`SEL_CLOCK_OUTPUT_SETTING_BIT] = s_reg.clock_output_setting;
        rd[`SEL_SUT_MSB:`SEL_SUT_LSB] = s_reg.csut;
        rd[`SEL_SRC_MSB:0] = s_reg.csel;
      end
      default: rd = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    avail_cmd = 1'b0;
    s_next.strobe = 1'b0;

    // Asynchronous status inputs pass two flops
    s_next.lock_s1 = pll_lock_raw;
    s_next.lock_s2 = s_reg.lock_s1;
    s_next.avail_s1 = clk_avail_raw;
    s_next.avail_s2 = s_reg.avail_s1;

    // Fuse values are caught in the first cycle after reset release
    if (!s_reg.init_done)
    begin
      s_next.init_done = 1'b1;
      s_next.csel = boot_source_fuse;
      s_next.csut = startup_fuse;
      s_next.clock_output_setting = clock_output_fuse;
      s_next.rc_sel = (boot_source_fuse == `RC1_BOOT_CODE);
    end

    // Unlock window runs down on its own
    if (s_reg.unlock)
    begin
      if (s_reg.unlock_cnt == `CNT_ZERO)
        s_next.unlock = 1'b0;
      else
        s_next.unlock_cnt = s_reg.unlock_cnt - `CNT_STEP;
    end

    // Address and data are taken in either order
    if (awvalid && awready)
    begin
      s_next.aw_full = 1'b1;
      s_next.aw_reg = reg_sel(awaddr);
    end
    if (wvalid && wready)
    begin
      s_next.w_full = 1'b1;
      s_next.w_data = wdata[7:0];
      s_next.w_lane = wstrb[0];
    end
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;

    // Write is carried out once both halves are held
    if (s_reg.aw_full && s_reg.w_full)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = (s_reg.aw_reg == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      if (s_reg.w_lane)
      begin
        unique case (s_reg.aw_reg)
          REG_PLL:
          begin
            s_next.pll_factor = s_reg.w_data[`PLL_F_MSB:`PLL_F_LSB];
            s_next.pll_on = s_reg.w_data[`PLL_ON_BIT];
          end
          REG_MCU:
          begin
            // Software must not pick 1 MHz under the PLL; no guard here
            if (rc_enable)
              s_next.rc_sel = s_reg.w_data[`RC_SEL_BIT];
          end
          REG_CMD:
          begin
            if (s_reg.w_data == `UNLOCK_KEY)
            begin
              // A rewrite inside the window is ignored
              if (!s_reg.unlock)
              begin
                s_next.unlock = 1'b1;
                s_next.unlock_cnt = `UNLOCK_LAST;
              end
            end
            else if (s_reg.unlock && !s_reg.w_data[`CMD_UNLOCK_BIT])
            begin
              s_next.unlock = 1'b0;
              s_next.cmd_code = s_reg.w_data[`CMD_CODE_MSB:0];
              s_next.op = cmd_t'(s_reg.w_data[`CMD_CODE_MSB:0]);
              unique case (s_reg.w_data[`CMD_CODE_MSB:0])
                CMD_DISABLE, CMD_ENABLE, CMD_CLKOUT:
                  s_next.strobe = 1'b1;
                CMD_AVAIL:
                begin
                  s_next.strobe = 1'b1;
                  s_next.ready = 1'b0;
                  s_next.avail_pend = 1'b1;
                  avail_cmd = 1'b1;
                end
                CMD_SWITCH:
                begin
                  // Both externals share one pin, so a direct hop is dropped
                  if (!((current_source_code == ext_clk_code && s_reg.csel == ext_osc_code)
                    || (current_source_code == ext_osc_code && s_reg.csel == ext_clk_code)))
                    s_next.strobe = 1'b1;
                end
                CMD_RECOVER:
                begin
                  // Start-up and clock output fields are left alone
                  s_next.csel = current_source_code;
                  s_next.strobe = 1'b1;
                end
                default: ;
              endcase
            end
          end
          REG_SEL:
          begin
            s_next.clock_output_setting = s_reg.w_data[`SEL_CLOCK_OUTPUT_SETTING_BIT];
            s_next.csut = s_reg.w_data[`SEL_SUT_MSB:`SEL_SUT_LSB];
            s_next.csel = s_reg.w_data[`SEL_SRC_MSB:0];
          end
          default: ;
        endcase
      end
    end

    // Ready set wins over a request entered in the same cycle
    if (s_reg.avail_pend && s_reg.avail_s2)
    begin
      s_next.ready = 1'b1;
      if (!avail_cmd)
        s_next.avail_pend = 1'b0;
    end

    // RC off forces the 8 MHz selection back
    if (!rc_enable)
      s_next.rc_sel = 1'b0;

    // Read answer one cycle after the address
    if (s_reg.rvalid && rready)
      s_next.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd;
      s_next.rresp = (reg_sel(araddr) == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.pll_factor <= `PLL_F_RST;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_unlock_source: assert property ($rose(s_reg.unlock) |-> $past(key_wr))
    else $error("unlock rose without a lone unlock write");
  a_unlock_timeout: assert property (s_reg.unlock [*4] |=> !s_reg.unlock)
    else $error("unlock window longer than four cycles");
  a_unlock_holds: assert property (s_reg.unlock && !cmd_wr
    && s_reg.unlock_cnt != `CNT_ZERO |=> s_reg.unlock && $stable(s_reg.unlock_cnt) == 1'b0)
    else $error("unlock window cut short or extended");
  a_cmd_unlocked: assert property (s_reg.strobe |-> $past(s_reg.unlock))
    else $error("command issued without unlock");
  a_strobe_pulse: assert property (s_reg.strobe |=> !s_reg.strobe)
    else $error("command strobe longer than one cycle");
  a_no_cmd_codes: assert property (s_reg.strobe |-> !s_reg.op[3]
    && s_reg.op != CMD_SPARE && s_reg.op != CMD_NONE)
    else $error("strobe on a no command code");
  a_ready_clear: assert property (s_reg.strobe && s_reg.op == CMD_AVAIL
    |-> !s_reg.ready || $past(s_reg.avail_pend && s_reg.avail_s2))
    else $error("ready not cleared by availability request");
  a_ready_set: assert property (s_reg.avail_pend && s_reg.avail_s2 |=> s_reg.ready)
    else $error("ready not set after clock confirmed");
  a_recover_load: assert property (s_reg.strobe && s_reg.op == CMD_RECOVER
    |-> s_reg.csel == $past(current_source_code) && $stable(s_reg.csut) && $stable(s_reg.clock_output_setting))
    else $error("recover did not load current source");
  a_pll_reads_one: assert property (arvalid && arready
    && reg_sel(araddr) == REG_PLL && sys_src_is_pll |=> rdata[`PLL_ON_BIT])
    else $error("pll enable read zero while pll is system clock");
  a_rc_sel_clear: assert property (!rc_enable |=> !s_reg.rc_sel)
    else $error("rc select kept while rc is off");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");

  c_cmd_issued: cover property (s_reg.unlock ##[1:4] s_reg.strobe);
  c_ready_set: cover property ($rose(s_reg.ready));
  c_recover: cover property (s_reg.strobe && s_reg.op == CMD_RECOVER);
  c_switch: cover property (s_reg.strobe && s_reg.op == CMD_SWITCH);

endmodule // pll_and_clock_switch_control

// File: core/clkctl_consts.svh
// Register indices, field positions, reset values and counts for the clock control block
`ifndef CLKCTL_CONSTS_SVH
`define CLKCTL_CONSTS_SVH

// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PLL 8'h29
`define IDX_MCU 8'h2A
`define IDX_CMD 8'h2B
`define IDX_SEL 8'h2C
`define ADDR_HI_ZERO 22'h00_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PLL_LOCK_BIT 0
`define PLL_ON_BIT 1
`define PLL_F_LSB 2
`define PLL_F_MSB 5
`define RC_SEL_BIT 2
`define CMD_UNLOCK_BIT 7
`define CMD_READY_BIT 4
`define CMD_CODE_MSB 3
`define SEL_CLOCK_OUTPUT_SETTING_BIT 6
`define SEL_SUT_MSB 5
`define SEL_SUT_LSB 4
`define SEL_SRC_MSB 3

// ----------------------------------------------------------------
// Values and counts
// ----------------------------------------------------------------
`define PLL_F_RST 4'h4
`define PLL_F_MIN 4'h2
`define PLL_F_MAX 4'h6
`define RC1_BOOT_CODE 4'h6
`define UNLOCK_KEY 8'h80
`define UNLOCK_LAST 2'h3
`define CNT_ZERO 2'h0
`define CNT_STEP 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: core/clkctl_pkg.sv
// Types shared by the clock control block
package clkctl_pkg;

  // Clock switch commands
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_DISABLE = 4'h1,
    CMD_ENABLE = 4'h2,
    CMD_AVAIL = 4'h3,
    CMD_SWITCH = 4'h4,
    CMD_RECOVER = 4'h5,
    CMD_SPARE = 4'h6,
    CMD_CLKOUT = 4'h7
  } cmd_t;

  // Decoded register target
  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_PLL = 3'h1,
    REG_MCU = 3'h2,
    REG_CMD = 3'h3,
    REG_SEL = 3'h4
  } reg_t;

  // Whole state of the block
  typedef struct packed {
    logic aw_full;
    reg_t aw_reg;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [3:0] pll_factor;
    logic pll_on;
    logic rc_sel;
    logic unlock;
    logic [1:0] unlock_cnt;
    logic [3:0] cmd_code;
    logic ready;
    logic avail_pend;
    logic clock_output_setting;
    logic [1:0] csut;
    logic [3:0] csel;
    logic strobe;
    cmd_t op;
    logic init_done;
    logic lock_s1;
    logic lock_s2;
    logic avail_s1;
    logic avail_s2;
  } state_t;

endpackage

// File: tb/pll_and_clock_switch_control_test.sv
// Self-checking bench for the PLL and clock switch control block
`timescale 1ns/100ps
`include "clkctl_consts.svh"

module pll_and_clock_switch_control_test;
  import clkctl_pkg::*;
  // ----------------------------------------------------------------
  // Signals and register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] a_pll = {`ADDR_HI_ZERO, `IDX_PLL, 2'b00};
  localparam logic [31:0] a_mcu = {`ADDR_HI_ZERO, `IDX_MCU, 2'b00};
  localparam logic [31:0] a_cmd = {`ADDR_HI_ZERO, `IDX_CMD, 2'b00};
  localparam logic [31:0] a_sel = {`ADDR_HI_ZERO, `IDX_SEL, 2'b00};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, startup_fuse, cmd_startup;
  logic [31:0] rdata, rd_val;
  logic [1:0] wr_resp, rd_resp;
  logic pll_lock_raw, clk_avail_raw, sys_src_is_pll, rc_active_in, clock_output_fuse;
  logic [3:0] current_source_code, boot_source_fuse, pll_mult_factor, cmd_op, cmd_source;
  logic pll_enable, pll_locked, pll_factor_ok, rc_enable, rc_freq_select;
  logic clock_ready_flag, cmd_strobe, cmd_clkout;
  int n_fail, check_count;
  int n_strobe = 0;

  pll_and_clock_switch_control i_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .pll_lock_raw(pll_lock_raw),
    .clk_avail_raw(clk_avail_raw), .sys_src_is_pll(sys_src_is_pll),
    .rc_active_in(rc_active_in), .current_source_code(current_source_code),
    .boot_source_fuse(boot_source_fuse), .startup_fuse(startup_fuse),
    .clock_output_fuse(clock_output_fuse), .pll_enable(pll_enable),
    .pll_locked(pll_locked), .pll_mult_factor(pll_mult_factor),
    .pll_factor_ok(pll_factor_ok), .rc_enable(rc_enable),
    .rc_freq_select(rc_freq_select), .clock_ready_flag(clock_ready_flag),
    .cmd_strobe(cmd_strobe), .cmd_op(cmd_op), .cmd_source(cmd_source),
    .cmd_startup(cmd_startup), .cmd_clkout(cmd_clkout)
  );

  // Clock at 100 MHz
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Strobe counter, so one-cycle pulses are never missed
  always @(posedge aclk)
    if (cmd_strobe === 1'b1) n_strobe++;

  // ----------------------------------------------------------------
  // Bus and compare tasks (entered just after a rising edge)
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    n_fail++;
    $display("mismatch %s expected handshake seen none", what);
    report_and_stop();
  endtask

  // Write address and data offered together; bready stays high throughout
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int i;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 50) timeout("write");
    wr_resp = bresp;
  endtask

  task automatic rd(input logic [31:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 50) timeout("read");
    rd_val = rdata;
    rd_resp = rresp;
  endtask

  task automatic rdc(input string what, input logic [31:0] a, input logic [7:0] exp);
    rd(a);
    chk(what, {24'h00_0000, exp}, rd_val);
  endtask

  // Unlock then command; counts strobes that result
  task automatic cmd_try(input logic [7:0] d, input int exp);
    int s;
    s = n_strobe;
    wr(a_cmd, `UNLOCK_KEY);
    wr(a_cmd, d);
    repeat (1) @(posedge aclk);
    chk("strobe count", exp, n_strobe - s);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc("pll reset", a_pll, 8'h10);
    rdc("mcu reset", a_mcu, 8'h04);
    rdc("cmd reset", a_cmd, 8'h00);
    rdc("sel from fuses", a_sel, 8'h66);
    rd(32'h0000_00b4);
    chk("unmapped rresp", `RESP_SLVERR, rd_resp);
    wr(32'h0000_00b4, 8'hff);
    chk("unmapped bresp", `RESP_SLVERR, wr_resp);
    $display("test reset done");
  endtask

  task automatic t_pll();
    wr(a_pll, 8'h18);
    rdc("pll factor 6", a_pll, 8'h18);
    chk("factor ok", 1, pll_factor_ok);
    wr(a_pll, 8'h1c);
    chk("factor 7 reserved", 0, pll_factor_ok);
    sys_src_is_pll <= 1'b1;
    wr(a_pll, 8'h08);
    rdc("enable forced", a_pll, 8'h0a);
    chk("pll enable", 1, pll_enable);
    pll_lock_raw <= 1'b1;
    repeat (5) @(posedge aclk);
    rdc("locked bit", a_pll, 8'h0b);
    // Low byte lane off: the write must leave the register alone
    wstrb <= 4'he;
    wr(a_pll, 8'h00);
    wstrb <= 4'hf;
    chk("masked bresp", `RESP_OKAY, wr_resp);
    rdc("masked write", a_pll, 8'h0b);
    sys_src_is_pll <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("lock needs enable", 0, pll_locked);
    pll_lock_raw <= 1'b0;
    $display("test pll done");
  endtask

  task automatic t_rc();
    rc_active_in <= 1'b0;
    repeat (2) @(posedge aclk);
    rdc("rc off clears", a_mcu, 8'h00);
    wr(a_mcu, 8'h04);
    rdc("rc off write", a_mcu, 8'h00);
    wr(a_pll, 8'h0a);
    chk("rc reference", 1, rc_enable);
    wr(a_pll, 8'h08);
    rc_active_in <= 1'b1;
    wr(a_mcu, 8'h04);
    rdc("rc 1 MHz", a_mcu, 8'h04);
    chk("rc select pin", 1, rc_freq_select);
    rc_active_in <= 1'b0;
    repeat (2) @(posedge aclk);
    rdc("rc cleared", a_mcu, 8'h00);
    rc_active_in <= 1'b1;
    $display("test rc done");
  endtask

  task automatic t_unlock();
    int s;
    wr(a_cmd, `UNLOCK_KEY);
    rdc("unlock open", a_cmd, 8'h80);
    repeat (2) @(posedge aclk);
    rdc("unlock expired", a_cmd, 8'h00);
    s = n_strobe;
    wr(a_cmd, 8'h81);
    wr(a_cmd, 8'h02);
    wr(a_cmd, `UNLOCK_KEY);
    wr(a_cmd, `UNLOCK_KEY);
    wr(a_cmd, 8'h02);
    repeat (1) @(posedge aclk);
    chk("no strobe", 0, n_strobe - s);
    rdc("code kept", a_cmd, 8'h00);
    $display("test unlock done");
  endtask

  task automatic t_cmds();
    logic [3:0] codes [9];
    int exp [9];
    int k;
    codes = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h0, 4'h6, 4'h8, 4'hf};
    exp = '{1, 1, 1, 1, 1, 0, 0, 0, 0};
    current_source_code <= 4'h9;
    for (k = 0; k < 9; k++)
    begin
      cmd_try({4'h6, codes[k]}, exp[k]);
      if (exp[k] == 1) chk("op", codes[k], cmd_op);
      rdc("code readback", a_cmd, {4'h0, codes[k]});
    end
    rdc("recovered", a_sel, 8'h69);
    chk("source out", 4'h9, cmd_source);
    chk("startup out", 2'h2, cmd_startup);
    chk("clkout out", 1, cmd_clkout);
    $display("test commands done");
  endtask

  task automatic t_avail();
    int i;
    cmd_try(8'h03, 1);
    rdc("ready low", a_cmd, 8'h03);
    clk_avail_raw <= 1'b1;
    for (i = 0; i < 20 && clock_ready_flag !== 1'b1; i++)
      @(posedge aclk);
    if (i == 20) timeout("ready");
    rdc("ready high", a_cmd, 8'h13);
    clk_avail_raw <= 1'b0;
    repeat (4) @(posedge aclk);
    cmd_try(8'h03, 1);
    chk("ready cleared", 0, clock_ready_flag);
    $display("test availability done");
  endtask

  task automatic t_switch();
    current_source_code <= 4'h0;
    wr(a_sel, 8'h61);
    cmd_try(8'h04, 0);
    wr(a_sel, 8'h62);
    cmd_try(8'h04, 1);
    // Poll by recover until the target source shows up
    cmd_try(8'h05, 1);
    rdc("switch pending", a_sel, 8'h60);
    current_source_code <= 4'h2;
    cmd_try(8'h05, 1);
    rdc("switch done", a_sel, 8'h62);
    $display("test switch done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid, pll_lock_raw, clk_avail_raw, sys_src_is_pll} = 6'h00;
    {bready, rready, rc_active_in, clock_output_fuse} = 4'hf;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    current_source_code = 4'h6;
    boot_source_fuse = `RC1_BOOT_CODE;
    startup_fuse = 2'h2;
    n_fail = 0;
    check_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_pll();
    t_rc();
    t_unlock();
    t_cmds();
    t_avail();
    t_switch();
    report_and_stop();
  end
endmodule // pll_and_clock_switch_control_test
